/* rfc_converter.sv */
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module rfc_converter (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [rfc_pkg::RFC_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic internal_oscillator,
    input wire logic slow_crystal_oscillator,
    input wire logic fast_oscillator,
    input wire logic osc_feedback,
    output rfc_pkg::rfc_drive_t osc_drive
);
    import rfc_pkg::*;

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------
    // low-bit mask for a power-of-two division code
    function automatic logic [2:0] div_mask(input logic [1:0] code);
        case (code)
            2'h0: div_mask = 3'h0;
            2'h1: div_mask = 3'h1;
            2'h2: div_mask = 3'h3;
            default: div_mask = 3'h7;
        endcase
    endfunction : div_mask

    // one-hot trigger pick, reference first then A then B
    function automatic rfc_phase_t pick_run(input logic [2:0] bits);
        if (bits[FLG_REF]) begin
            pick_run = PH_REF;
        end else if (bits[FLG_A]) begin
            pick_run = PH_SEN_A;
        end else if (bits[FLG_B]) begin
            pick_run = PH_SEN_B;
        end else begin
            pick_run = PH_IDLE;
        end
    endfunction : pick_run

    // ------------------------------------------------------------
    // state and registers
    // ------------------------------------------------------------
    converter_clock_control_t clk_r;            // clock control
    converter_control_t ctl_r;            // converter control
    rfc_phase_t phase;          // which oscillation runs
    rfc_phase_t next_phase;
    logic [23:0] mc;            // measurement counter
    logic [23:0] tc;            // time base counter
    logic [23:0] next_mc;
    logic [23:0] next_tc;
    logic [4:0] mask;           // interrupt enables
    logic [4:0] flags;          // sticky interrupt flags
    logic [4:0] next_flags;
    logic [2:0] prescale;       // converter clock divider
    logic [3:0] sync1;          // first synchroniser stage
    logic [3:0] sync2;          // second stage, read by the edge detector with sync3
    logic [3:0] sync3;          // delayed copy for edge detection

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // all four inputs come from foreign oscillators
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
            sync3 <= 4'h0;
        end else begin
            sync1 <= {osc_feedback, fast_oscillator,
                      slow_crystal_oscillator, internal_oscillator};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    wire [3:0] rise = sync2 & ~sync3;   // rising edge per input
    wire osc_edge = rise[3];            // sensor/reference edge

    // ------------------------------------------------------------
    // converter clock selection and division
    // ------------------------------------------------------------
    // source code 0x3 is reserved and yields no clock at all
    wire src_edge = (clk_r.src == SRC_INTERNAL) ? rise[0] :
                    (clk_r.src == SRC_SLOW) ? rise[1] :
                    (clk_r.src == SRC_FAST) ? rise[2] : 1'b0;
    // the slow crystal is never divided
    wire [1:0] eff_div = (clk_r.src == SRC_SLOW) ? 2'h0 : clk_r.div;
    wire [2:0] eff_mask = div_mask(eff_div);
    wire active = clk_r.en & ctl_r.on;
    wire tick = active & src_edge &
                ((prescale & eff_mask) == eff_mask);

    // prescaler only advances while the converter is enabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale <= 3'h0;
        end else if (!active) begin
            prescale <= 3'h0;
        end else if (src_edge) begin
            prescale <= prescale + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire [14:0] widx = paddr[RFC_AW-1:2];
    wire hit_clk = (widx == IDX_CLK);
    wire hit_ctl = (widx == IDX_CTL);
    wire hit_trg = (widx == IDX_TRG);
    wire hit_mcl = (widx == IDX_MCL);
    wire hit_mch = (widx == IDX_MCH);
    wire hit_tcl = (widx == IDX_TCL);
    wire hit_tch = (widx == IDX_TCH);
    wire hit_msk = (widx == IDX_MSK);
    wire hit_flg = (widx == IDX_FLG);
    wire mapped = hit_clk | hit_ctl | hit_trg | hit_mcl | hit_mch |
                  hit_tcl | hit_tch | hit_msk | hit_flg;
    // request is taken on the edge where pready is seen high
    wire xfer = psel & penable & pready;
    wire wr = xfer & pwrite;
    wire rd_flg = xfer & ~pwrite & hit_flg;

    // read data, reserved bits as zero
    wire [2:0] trg_bits = {phase == PH_SEN_B, phase == PH_SEN_A,
                           phase == PH_REF};
    wire [31:0] rd_data =
        hit_clk ? {26'h0, clk_r.div, clk_r.src, 1'b0, clk_r.en} :
        hit_ctl ? {24'h0, ctl_r.cont, ctl_r.evt, ctl_r.stype, 2'h0,
                   ctl_r.chan, ctl_r.on} :
        hit_trg ? {29'h0, trg_bits} :
        hit_mcl ? {16'h0, mc[15:0]} :
        hit_mch ? {24'h0, mc[23:16]} :
        hit_tcl ? {16'h0, tc[15:0]} :
        hit_tch ? {24'h0, tc[23:16]} :
        hit_msk ? {27'h0, mask} :
        hit_flg ? {27'h0, flags} : 32'h0;

    // no wait state: pready rises in the cycle after setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= psel & ~pready;
            pslverr <= psel & ~pready & ~mapped;
            prdata <= (psel & ~pready & ~pwrite) ? rd_data : 32'h0;
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_r <= CLK_RST;
            ctl_r <= CTL_RST;
            mask <= FLG_RST;
        end else begin
            if (wr & hit_clk) begin
                clk_r <= '{div: pwdata[5:4], src: pwdata[3:2],
                           en: pwdata[0]};
            end
            if (wr & hit_ctl) begin
                ctl_r <= '{cont: pwdata[7], evt: pwdata[6],
                           stype: pwdata[5:4], chan: pwdata[1],
                           on: pwdata[0]};
            end
            if (wr & hit_msk) begin
                mask <= pwdata[4:0];
            end
        end
    end

    // ------------------------------------------------------------
    // oscillation sequencing
    // ------------------------------------------------------------
    wire sensing = (phase == PH_SEN_A) | (phase == PH_SEN_B);
    wire running = (phase != PH_IDLE);
    // reference counts up on both counters; done at measurement wrap
    wire ref_done = (phase == PH_REF) & ~ctl_r.evt & osc_edge &
                    (mc == CNT_MAX);
    // sensor: time base counts down from the reference result
    wire sen_done = sensing & ~ctl_r.evt & tick & (tc == CNT_ONE);
    wire tc_ovf = (phase == PH_REF) & ~ctl_r.evt & tick &
                  (tc == CNT_MAX);
    wire mc_ovf = running & osc_edge & (mc == CNT_MAX) &
                  ((phase != PH_REF) | ctl_r.evt);
    // continuous mode flags completion but keeps going
    wire stop_now = tc_ovf | mc_ovf |
                    ((ref_done | sen_done) & ~ctl_r.cont);
    wire trg_wr = wr & hit_trg;

    // next phase; software may also stop a run by writing zero
    always_comb begin
        next_phase = phase;
        case (phase)
            PH_IDLE: begin
                if (trg_wr & active) begin
                    next_phase = pick_run(pwdata[2:0]);
                end
            end
            PH_REF, PH_SEN_A, PH_SEN_B: begin
                if (!active) begin
                    next_phase = PH_IDLE;
                end else if (trg_wr) begin
                    next_phase = pick_run(pwdata[2:0]);
                end else if (stop_now) begin
                    next_phase = PH_IDLE;
                end
            end
            default: begin
                next_phase = PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= PH_IDLE;
        end else begin
            phase <= next_phase;
        end
    end

    // ------------------------------------------------------------
    // counters
    // ------------------------------------------------------------
    // event mode counts feedback edges only, time base frozen
    always_comb begin
        next_mc = mc;
        next_tc = tc;
        if (running & osc_edge) begin
            next_mc = mc + CNT_ONE;
        end
        if (running & tick & ~ctl_r.evt) begin
            next_tc = (phase == PH_REF) ? tc + CNT_ONE :
                                          tc - CNT_ONE;
        end
        // software write wins over a count in the same cycle
        if (wr & hit_mcl) begin
            next_mc = {mc[23:16], pwdata[15:0]};
        end
        if (wr & hit_mch) begin
            next_mc = {pwdata[7:0], mc[15:0]};
        end
        if (wr & hit_tcl) begin
            next_tc = {tc[23:16], pwdata[15:0]};
        end
        if (wr & hit_tch) begin
            next_tc = {pwdata[7:0], tc[15:0]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mc <= 24'h0;
            tc <= 24'h0;
        end else begin
            mc <= next_mc;
            tc <= next_tc;
        end
    end

    // ------------------------------------------------------------
    // interrupt flags
    // ------------------------------------------------------------
    wire [4:0] flag_set = {tc_ovf, mc_ovf,
                           sen_done & (phase == PH_SEN_B),
                           sen_done & (phase == PH_SEN_A),
                           ref_done};
    // a write of one or a read clears; a new event beats the clear
    wire [4:0] flag_clr = ((wr & hit_flg) ? pwdata[4:0] : 5'h00) |
                          (rd_flg ? 5'h1f : 5'h00);
    assign next_flags = (flags & ~flag_clr) | flag_set;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= FLG_RST;
            irq <= 1'b0;
        end else begin
            flags <= next_flags;
            irq <= |(next_flags & ((wr & hit_msk) ? pwdata[4:0] :
                                   mask));
        end
    end

    // ------------------------------------------------------------
    // oscillator circuit control
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_drive <= '0;
        end else begin
            osc_drive <= '{sensor_type_code: ctl_r.stype,
                           channel_choice: ctl_r.chan,
                           reference_run: next_phase == PH_REF,
                           sensor_a_run: next_phase == PH_SEN_A,
                           sensor_b_run: next_phase == PH_SEN_B};
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_ref_wrap;
        phase == PH_REF && !ctl_r.evt && osc_edge && mc == CNT_MAX;
    endsequence

    sequence s_sen_end;
        sensing && !ctl_r.evt && tick && tc == CNT_ONE && !ctl_r.cont;
    endsequence

    a_idle_when_off: assert property (@(posedge pclk) disable iff (!presetn)
        !active |=> phase == PH_IDLE)
        else $error("run continued with converter disabled");

    a_ref_done_flag: assert property (@(posedge pclk) disable iff (!presetn)
        s_ref_wrap |=> flags[FLG_REF])
        else $error("reference completion flag missed");

    a_sensor_stops: assert property (
        @(posedge pclk) disable iff (!presetn)
        (s_sen_end and !trg_wr) |=> phase == PH_IDLE &&
        !osc_drive.sensor_a_run && !osc_drive.sensor_b_run)
        else $error("sensor run did not stop at end");

    a_flag_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
        flag_set[FLG_MC_OVF] |=> flags[FLG_MC_OVF])
        else $error("overflow event lost against clear");

    a_flag_w1c: assert property (@(posedge pclk) disable iff (!presetn)
        wr && hit_flg && pwdata[FLG_TB_OVF] && !tc_ovf
        |=> !flags[FLG_TB_OVF])
        else $error("time base overflow flag not cleared");

    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 irq == |(flags & mask))
        else $error("irq disagrees with flags and mask");

    a_tick_spacing: assert property (@(posedge pclk) disable iff (!presetn)
        tick && eff_div != 2'h0 |=> !tick [*3])
        else $error("divided clock ticked too soon");

    a_slow_undivided: assert property (@(posedge pclk)
        disable iff (!presetn)
        active && clk_r.src == SRC_SLOW && rise[1] |-> tick)
        else $error("slow source was divided");

    a_trig_start: assert property (@(posedge pclk) disable iff (!presetn)
        phase == PH_IDLE && active && trg_wr && pwdata[2:0] == TRG_B
        |=> phase == PH_SEN_B ##1 osc_drive.sensor_b_run)
        else $error("sensor B run did not start");

    a_mcl_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr && hit_mcl |=> mc[15:0] == $past(pwdata[15:0]))
        else $error("measurement low write lost");

    a_channel_out: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 osc_drive.channel_choice == $past(ctl_r.chan))
        else $error("channel output wrong");

    a_reserved_zero: assert property (@(posedge pclk)
        disable iff (!presetn)
        pready && psel && !pwrite |-> prdata[31:8] == 24'h0 ||
        $past(hit_mcl || hit_tcl))
        else $error("reserved read bits not zero");

endmodule : rfc_converter

/* rfc_osc_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// sensor oscillator stand-in
// ----------------------------------------
module rfc_osc_model (
    input wire logic slow,
    input wire rfc_pkg::rfc_drive_t drive,
    output logic fb
);
    import rfc_pkg::*;
    // swings only while a run line is up, else rests low
    initial begin
        fb = 1'b0;
        forever begin
            if (drive.reference_run | drive.sensor_a_run |
                drive.sensor_b_run) begin
                #(slow ? 250 : 100) fb = ~fb;
            end else begin
                fb = 1'b0;
                @(drive);
            end
        end
    end
endmodule : rfc_osc_model

/* rfc_pkg.sv */
package rfc_pkg;
    // ------------------------------------------------------------
    // register map: printed offsets are word indices
    // ------------------------------------------------------------
    localparam int RFC_AW = 17;                 // byte address width
    localparam logic [14:0] IDX_CLK = 15'h5067; // clock control
    localparam logic [14:0] IDX_CTL = 15'h53a0; // control
    localparam logic [14:0] IDX_TRG = 15'h53a2; // oscillation trigger
    localparam logic [14:0] IDX_MCL = 15'h53a4; // measurement low
    localparam logic [14:0] IDX_MCH = 15'h53a6; // measurement high
    localparam logic [14:0] IDX_TCL = 15'h53a8; // time base low
    localparam logic [14:0] IDX_TCH = 15'h53aa; // time base high
    localparam logic [14:0] IDX_MSK = 15'h53ac; // interrupt mask
    localparam logic [14:0] IDX_FLG = 15'h53ae; // interrupt flags
    // ------------------------------------------------------------
    // codes, fields and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] SRC_INTERNAL = 2'h0;
    localparam logic [1:0] SRC_SLOW = 2'h1;
    localparam logic [1:0] SRC_FAST = 2'h2;
    localparam int CNT_W = 24;                  // counter width
    localparam logic [23:0] CNT_MAX = 24'hffffff;
    localparam logic [23:0] CNT_ONE = 24'h000001;
    localparam int FLG_TB_OVF = 4;              // flag/mask bit spots
    localparam int FLG_MC_OVF = 3;
    localparam int FLG_B = 2;
    localparam int FLG_A = 1;
    localparam int FLG_REF = 0;
    localparam logic [4:0] FLG_RST = 5'h00;
    localparam logic [2:0] TRG_REF = 3'h1;      // trigger one-hots
    localparam logic [2:0] TRG_A = 3'h2;
    localparam logic [2:0] TRG_B = 3'h4;
    // clock control fields, bits 5:4, 3:2 and 0
    typedef struct packed {
        logic [1:0] div;
        logic [1:0] src;
        logic en;
    } converter_clock_control_t;
    localparam converter_clock_control_t CLK_RST = '{div: 2'h0, src: SRC_SLOW, en: 1'b0};
    // control fields, bits 7, 6, 5:4, 1 and 0
    typedef struct packed {
        logic cont;
        logic evt;
        logic [1:0] stype;
        logic chan;
        logic on;
    } converter_control_t;
    localparam converter_control_t CTL_RST = '0;
    // oscillator circuit control bundle
    typedef struct packed {
        logic [1:0] sensor_type_code;
        logic channel_choice;
        logic reference_run;
        logic sensor_a_run;
        logic sensor_b_run;
    } rfc_drive_t;
    typedef enum logic [1:0] {PH_IDLE, PH_REF, PH_SEN_A, PH_SEN_B}
        rfc_phase_t;
endpackage : rfc_pkg

/* tb.sv */
`timescale 1ns/1ps
module tb;
    import rfc_pkg::*;
    // ----------------------------------------
    // pins, sources and design
    // ----------------------------------------
    logic pclk = 1'b0, presetn = 1'b0, slow_fb = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [RFC_AW-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic pready, pslverr, irq, fb;
    logic osc_i = 1'b0, osc_s = 1'b0, osc_f = 1'b0;
    rfc_drive_t drive;
    int errors = 0, total_checks = 0;
    // expected read: checked or not, error, value
    typedef struct packed {logic care; logic err; logic [31:0] val;}
        rfc_exp_t;
    rfc_exp_t exp_q[$];
    rfc_exp_t cur;
    initial forever #12.5 pclk = ~pclk;
    // raw sources, phase unrelated to pclk, all under 10 MHz
    initial forever #101 osc_i = ~osc_i;
    initial forever #149 osc_s = ~osc_s;
    initial forever #97 osc_f = ~osc_f;
    rfc_converter DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .internal_oscillator(osc_i),
        .slow_crystal_oscillator(osc_s), .fast_oscillator(osc_f),
        .osc_feedback(fb), .osc_drive(drive));
    rfc_osc_model PARTNER (.slow(slow_fb), .drive(drive), .fb(fb));
    // ----------------------------------------
    // reporting and compares
    // ----------------------------------------
    task automatic fail(input string msg);
        $display("CHECK FAILED %0t %s", $time, msg);
        errors++;
    endtask : fail
    task automatic cmp_sig(input logic [31:0] got, want, input string m);
        total_checks++;
        if (got !== want) fail(m);
    endtask : cmp_sig
    task automatic cmp_read(input rfc_exp_t e);
        total_checks++;
        if (prdata !== e.val || pslverr !== e.err) fail("read value");
    endtask : cmp_read
    // read watcher: oldest note against each finished read
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            cur = exp_q.pop_front();
            if (cur.care) cmp_read(cur);
        end
    end
    task automatic settle();
        repeat (3) @(posedge pclk);
        #1;
    endtask : settle
    // ----------------------------------------
    // bus tasks
    // ----------------------------------------
    // one transfer; held until pready is seen at an edge
    task automatic apb(input logic w, input logic [14:0] idx,
        input logic [31:0] wd, output logic [31:0] rd);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) fail("no ready");
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [14:0] idx, input logic [31:0] d);
        logic [31:0] rd;
        apb(1'b1, idx, d, rd);
    endtask : wr
    task automatic rd_chk(input logic [14:0] idx, input logic [31:0] v,
        input logic e = 1'b0);
        logic [31:0] rd;
        exp_q.push_back('{1'b1, e, v});
        apb(1'b0, idx, 32'h0, rd);
    endtask : rd_chk
    task automatic set_cnt(input logic [14:0] lo, input logic [23:0] v);
        wr(lo, {16'h0, v[15:0]});
        wr(lo + 15'h2, {24'h0, v[23:16]});
    endtask : set_cnt
    // start a run, poll until it stops, then check flags and irq
    task automatic run(input logic [2:0] trg, input logic [23:0] mc, tc,
        input logic [4:0] flg, input logic irq_on, w1c, output int t);
        logic [31:0] rd;
        int n = 0;
        set_cnt(IDX_MCL, mc);
        set_cnt(IDX_TCL, tc);
        wr(IDX_TRG, {29'h0, trg});
        t = int'($time);
        settle();
        cmp_sig({drive.sensor_b_run, drive.sensor_a_run,
            drive.reference_run}, trg,
            "run line");
        rd_chk(IDX_TRG, {29'h0, trg});
        do begin
            exp_q.push_back('{1'b0, 1'b0, 32'h0});
            apb(1'b0, IDX_TRG, 32'h0, rd);
            n++;
        end while (rd[2:0] !== 3'h0 && n < 900);
        t = (int'($time) - t) / 25;
        if (n >= 900) fail("run never ends");
        settle();
        cmp_sig(irq, irq_on, "irq on event");
        if (w1c) begin
            wr(IDX_FLG, 32'h0);
            settle();
            cmp_sig(irq, irq_on, "zero write kept");
            wr(IDX_FLG, {27'h0, flg});
            flg = 5'h0;
        end
        rd_chk(IDX_FLG, {27'h0, flg});
        rd_chk(IDX_FLG, 32'h0);
        settle();
        cmp_sig(irq, 1'b0, "irq after clear");
    endtask : run
    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up
    // hang guard, far beyond the expected run length
    initial begin : watchdog
        #2_000_000;
        fail("timeout");
        wrap_up();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin : main
        logic [31:0] v;
        int dur[4];
        void'($urandom(32'hf5e5));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(IDX_CLK, 32'h4);
        for (int i = 0; i < 8; i++) begin
            rd_chk(IDX_CTL + 15'(2 * i), 32'h0);
        end
        rd_chk(15'h0, 32'h0, 1'b1);
        wr(IDX_CTL, '1);
        rd_chk(IDX_CTL, 32'hf3);
        wr(IDX_TRG, 32'h1);
        rd_chk(IDX_TRG, 32'h0);
        wr(IDX_CLK, '1);
        rd_chk(IDX_CLK, 32'h3d);
        wr(IDX_MSK, '1);
        rd_chk(IDX_MSK, 32'h1f);
        for (int i = 0; i < 4; i++) begin
            v = $urandom();
            wr(IDX_MCL + 15'(2 * i), v);
            v = v & (i[0] ? 32'hff : 32'hffff);
            rd_chk(IDX_MCL + 15'(2 * i), v);
        end
        for (int c = 0; c < 4; c++) begin
            wr(IDX_CTL, {26'h0, 2'(c), 2'h0, c[0], 1'b1});
            settle();
            cmp_sig({drive.sensor_type_code, drive.channel_choice},
                {2'(c), c[0]}, "mode lines");
        end
        wr(IDX_CLK, 32'h5);
        wr(IDX_CTL, 32'h1);
        run(TRG_A, 24'h0, 24'h3, 5'h02, 1'b1, 1'b1, dur[0]);
        slow_fb <= 1'b1;
        run(TRG_B, 24'hfffff0, '1, 5'h08, 1'b1, 1'b0, dur[0]);
        slow_fb <= 1'b0;
        wr(IDX_MSK, 32'h1e);
        run(TRG_REF, 24'hfffff0, '0, 5'h01, 1'b0, 1'b0, dur[0]);
        wr(IDX_MSK, 32'h1f);
        run(TRG_REF, '0, 24'hfffff8, 5'h10, 1'b1, 1'b0, dur[0]);
        wr(IDX_CTL, 32'h41);
        run(TRG_A, 24'hfffff0, 24'h3, 5'h08, 1'b1, 1'b0, dur[0]);
        wr(IDX_CTL, 32'h81);
        set_cnt(IDX_MCL, 24'h0);
        set_cnt(IDX_TCL, 24'h2);
        wr(IDX_TRG, {29'h0, TRG_A});
        repeat (100) @(posedge pclk);
        rd_chk(IDX_TRG, 32'h2);
        rd_chk(IDX_FLG, 32'h2);
        wr(IDX_TRG, 32'h0);
        rd_chk(IDX_TRG, 32'h0);
        wr(IDX_CTL, 32'h1);
        for (int d = 0; d < 4; d++) begin
            wr(IDX_CLK, {26'h0, 2'(d), d[0], 3'h1});
            run(TRG_A, '0, 24'h8, 5'h02, 1'b1, 1'b0, dur[d]);
        end
        for (int d = 1; d < 4; d++) begin
            v = 32'(dur[d] * 10 > dur[d - 1] * 13);
            cmp_sig(v, 32'h1, "divider rate");
        end
        wrap_up();
    end
endmodule : tb
